// File: i2h_pkg.sv
// constants, types and helpers for the two-wire bus master
`default_nettype none

package i2h_pkg;

    // clock and bus timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int SCL_QUARTER_NS = 2500;
    localparam int QUARTER_CYC_I =
        (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] QUARTER_CYC = 8'(QUARTER_CYC_I);
    localparam logic [7:0] HALF_LAST = 8'(2 * QUARTER_CYC_I - 1);

    // frame layout
    localparam logic [3:0] ACK_SLOT = 4'h8;

    // line levels at the open-drain enables
    localparam logic LINE_REL = 1'b1;
    localparam logic LINE_DRV = 1'b0;
    localparam logic [1:0] LINES_IDLE = 2'h3;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_CNT = 8'h00;
    localparam logic [3:0] RST_BIT = 4'h0;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_WAIT_FREE,
        ST_RESTART,
        ST_START_A,
        ST_START_B,
        ST_BIT_LOW,
        ST_BIT_HIGH,
        ST_HOLD,
        ST_STOP_A,
        ST_STOP_B,
        ST_STOP_C
    } i2h_state_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic rd;
        logic nack;
        logic [7:0] data;
    } i2h_cmd_t;

    typedef struct packed {
        logic [7:0] data;
        logic nack;
        logic lost;
    } i2h_rsp_t;

    // level the master puts on the data line for the current bit
    function automatic logic tx_level(input i2h_cmd_t c,
                                      input logic [3:0] bit_no,
                                      input logic [7:0] sh);
        logic lvl;
        lvl = LINE_REL;
        if (bit_no < ACK_SLOT) begin
            lvl = c.rd ? LINE_REL : sh[7];
        end else begin
            lvl = c.rd ? c.nack : LINE_REL;
        end
        return lvl;
    endfunction : tx_level

endpackage : i2h_pkg

`default_nettype wire

// File: i2h_sync.sv
// two-stage synchroniser for the clock and data lines
`default_nettype none

module i2h_sync
    import i2h_pkg::*;
(
    // system
    input wire logic ref_clk,
    input wire logic rstn,
    // raw lines in, synchronised lines out {clock, data}
    input wire logic [1:0] pin,
    output logic [1:0] pin_s
);

    logic [1:0] meta;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            meta <= LINES_IDLE;
            pin_s <= LINES_IDLE;
        end else begin
            meta <= pin;
            pin_s <= meta;
        end
    end

endmodule : i2h_sync

`default_nettype wire

// File: i2h_master.sv
// byte-level master for the shared two-wire open-drain bus
// Notes on behaviour
// - every exchange opens with Start, address, then one direction bit
// - Start is data falling while clock stays high
// - matching slave acknowledges address; roles follow the direction bit
// - address and data bytes go out most significant bit first
// - direction bit one means read, zero means write
// - acknowledge is the receiver pulling data low in the ninth slot
// - data changes only while clock is low; else Start or Stop
// - reading master acknowledges each byte except the last one
// - reading master ends with Stop where the last acknowledge goes
// - Stop is data rising while clock stays high
// - master may keep the bus with a repeated Start instead of Stop
// - single write, single read, or combined messages joined by restart
// - master waits until released clock really rises
// - no new message while bus busy; wait for idle
// - transmitter seeing data mismatch loses and releases data
// - losing master also releases clock and waits for Stop
// - winning transmitter carries on unchanged
// - lower address wins; equal addresses arbitrate on through data
// - each unit is eight data bits plus one acknowledge bit
// - data is sampled at the rising edge of the clock line
// - bus idle only with both lines high and no master active
`default_nettype none

module i2h_master
    import i2h_pkg::*;
(
    // system
    input wire logic ref_clk,
    input wire logic rstn,
    // command
    input wire logic cmd_valid,
    input wire i2h_cmd_t cmd,
    output logic cmd_ready,
    // response
    output logic rsp_valid,
    output i2h_rsp_t rsp,
    // bus state
    output logic bus_busy,
    // clock line
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    // data line
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n
);

    logic [1:0] line_s;
    logic scl_s;
    logic sda_s;
    logic scl_d;
    logic sda_d;
    logic seen_low;
    logic start_det;
    logic stop_det;
    i2h_state_t state;
    logic [7:0] cnt;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    i2h_cmd_t cur;
    logic hi_seen;
    logic ack_smp;
    logic tx_bit;

    // line sensing through two flip-flops
    i2h_sync u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pin({scl_i, sda_i}),
        .pin_s(line_s)
    );

    assign scl_s = line_s[1];
    assign sda_s = line_s[0];

    // condition detectors on the synchronised lines
    assign start_det = scl_s && scl_d && sda_d && !sda_s;
    assign stop_det = scl_s && scl_d && !sda_d && sda_s
                      && seen_low;

    // transmitting bits (not acknowledge, not reading)
    assign tx_bit = !cur.rd && (bit_cnt < ACK_SLOT);

    // open-drain pins only ever pull low
    always_ff @(posedge ref_clk) begin
        scl_o <= LINE_DRV;
        sda_o <= LINE_DRV;
    end

    // bus monitor: busy from Start until a valid Stop
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            scl_d <= LINE_REL;
            sda_d <= LINE_REL;
            seen_low <= 1'b0;
            bus_busy <= 1'b0;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            if (start_det) begin
                bus_busy <= 1'b1;
                seen_low <= 1'b0;
            end else if (stop_det) begin
                bus_busy <= 1'b0;
            end else if (!scl_s) begin
                seen_low <= 1'b1;
            end
        end
    end

    // bit-level sequencer
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state <= ST_IDLE;
            cnt <= RST_CNT;
            bit_cnt <= RST_BIT;
            shift <= RST_BYTE;
            cur <= '0;
            hi_seen <= 1'b0;
            ack_smp <= LINE_REL;
            scl_oe_n <= LINE_REL;
            sda_oe_n <= LINE_REL;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else begin
            rsp_valid <= 1'b0;
            cnt <= cnt + 8'h01;
            case (state)
                ST_IDLE: begin
                    cmd_ready <= 1'b1;
                    scl_oe_n <= LINE_REL;
                    sda_oe_n <= LINE_REL;
                    cnt <= RST_CNT;
                    if (cmd_valid && cmd_ready) begin
                        cur <= cmd;
                        shift <= cmd.data;
                        cmd_ready <= 1'b0;
                        state <= ST_WAIT_FREE;
                    end
                end
                ST_WAIT_FREE: begin
                    // both lines high for a quarter period, no owner
                    if (bus_busy || !scl_s || !sda_s) begin
                        cnt <= RST_CNT;
                    end else if (cnt == QUARTER_CYC) begin
                        cnt <= RST_CNT;
                        state <= ST_START_A;
                    end
                end
                ST_RESTART: begin
                    // clock held low; free data, then release clock
                    if (cnt == QUARTER_CYC) begin
                        sda_oe_n <= LINE_REL;
                    end
                    if (cnt == HALF_LAST) begin
                        scl_oe_n <= LINE_REL;
                        cnt <= RST_CNT;
                        state <= ST_START_A;
                    end
                end
                ST_START_A: begin
                    if (!scl_s) begin
                        cnt <= RST_CNT;
                    end else if (cnt == QUARTER_CYC) begin
                        cnt <= RST_CNT;
                        if (!sda_s) begin
                            // another master already holds data low
                            state <= ST_IDLE;
                            scl_oe_n <= LINE_REL;
                            sda_oe_n <= LINE_REL;
                            rsp_valid <= 1'b1;
                            rsp <= '{data: RST_BYTE, nack: LINE_REL,
                                     lost: 1'b1};
                        end else begin
                            sda_oe_n <= LINE_DRV;
                            state <= ST_START_B;
                        end
                    end
                end
                ST_START_B: begin
                    if (cnt == QUARTER_CYC) begin
                        scl_oe_n <= LINE_DRV;
                        bit_cnt <= RST_BIT;
                        cnt <= RST_CNT;
                        state <= ST_BIT_LOW;
                    end
                end
                ST_BIT_LOW: begin
                    if (cnt == QUARTER_CYC) begin
                        // data moves only in the clock-low half
                        sda_oe_n <= tx_level(cur, bit_cnt, shift);
                    end
                    if (cnt == HALF_LAST) begin
                        scl_oe_n <= LINE_REL;
                        hi_seen <= 1'b0;
                        cnt <= RST_CNT;
                        state <= ST_BIT_HIGH;
                    end
                end
                ST_BIT_HIGH: begin
                    if (!hi_seen) begin
                        cnt <= RST_CNT;
                        // stay here while a slave stretches the clock
                        if (scl_s) begin
                            hi_seen <= 1'b1;
                            if (bit_cnt < ACK_SLOT) begin
                                shift <= {shift[6:0], sda_s};
                            end else begin
                                ack_smp <= sda_s;
                            end
                            if (tx_bit && sda_oe_n && !sda_s) begin
                                // lost: free both lines at once
                                state <= ST_IDLE;
                                scl_oe_n <= LINE_REL;
                                sda_oe_n <= LINE_REL;
                                rsp_valid <= 1'b1;
                                rsp <= '{data: shift, nack: LINE_REL,
                                         lost: 1'b1};
                            end
                        end
                    end else if (!scl_s || cnt == HALF_LAST) begin
                        // end high half; another master may cut it short
                        scl_oe_n <= LINE_DRV;
                        cnt <= RST_CNT;
                        if (bit_cnt < ACK_SLOT) begin
                            bit_cnt <= bit_cnt + 4'h1;
                            state <= ST_BIT_LOW;
                        end else begin
                            rsp_valid <= 1'b1;
                            rsp <= '{data: shift,
                                     nack: cur.rd ? cur.nack : ack_smp,
                                     lost: 1'b0};
                            if (cur.stop) begin
                                state <= ST_STOP_A;
                            end else begin
                                cmd_ready <= 1'b1;
                                state <= ST_HOLD;
                            end
                        end
                    end
                end
                ST_HOLD: begin
                    // own the bus with the clock low until the next byte
                    cnt <= RST_CNT;
                    if (cmd_valid && cmd_ready) begin
                        cur <= cmd;
                        shift <= cmd.data;
                        cmd_ready <= 1'b0;
                        bit_cnt <= RST_BIT;
                        if (cmd.start) begin
                            state <= ST_RESTART;
                        end else begin
                            state <= ST_BIT_LOW;
                        end
                    end
                end
                ST_STOP_A: begin
                    if (cnt == QUARTER_CYC) begin
                        sda_oe_n <= LINE_DRV;
                    end
                    if (cnt == HALF_LAST) begin
                        scl_oe_n <= LINE_REL;
                        cnt <= RST_CNT;
                        state <= ST_STOP_B;
                    end
                end
                ST_STOP_B: begin
                    if (!scl_s) begin
                        cnt <= RST_CNT;
                    end else if (cnt == QUARTER_CYC) begin
                        sda_oe_n <= LINE_REL;
                        cnt <= RST_CNT;
                        state <= ST_STOP_C;
                    end
                end
                ST_STOP_C: begin
                    if (cnt == HALF_LAST) begin
                        cnt <= RST_CNT;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    AST_IDLE_RELEASED: assert property (
        state == ST_IDLE && $past(state) == ST_IDLE
        |-> scl_oe_n && sda_oe_n
    ) else $error("lines driven while idle");

    AST_LOST_FREES_LINES: assert property (
        rsp_valid && rsp.lost |-> scl_oe_n && sda_oe_n && state == ST_IDLE
    ) else $error("lost arbitration but still driving");

    AST_DATA_MOVES_CLOCK_LOW: assert property (
        $changed(sda_oe_n)
        && !(state inside {ST_START_B, ST_STOP_C, ST_IDLE})
        |-> !scl_oe_n
    ) else $error("data changed while clock released");

    AST_STRETCH_WAIT: assert property (
        state == ST_BIT_HIGH && !hi_seen && !scl_s
        |=> state == ST_BIT_HIGH && cnt == RST_CNT
    ) else $error("clock high phase ran while line held low");

    AST_BUSY_HOLDS_OFF: assert property (
        state == ST_WAIT_FREE && bus_busy |=> state == ST_WAIT_FREE
    ) else $error("start attempted on a busy bus");

    AST_MSB_FIRST: assert property (
        state == ST_BIT_LOW && cnt == QUARTER_CYC && tx_bit
        |=> sda_oe_n == $past(shift[7])
    ) else $error("data bit not most significant first");

    AST_READ_ACK_LEVEL: assert property (
        state == ST_BIT_LOW && cnt == QUARTER_CYC && cur.rd
        && bit_cnt == ACK_SLOT
        |=> sda_oe_n == $past(cur.nack)
    ) else $error("read acknowledge level wrong");

    AST_NINE_CLOCKS: assert property (
        rsp_valid && !rsp.lost |-> $past(bit_cnt) == ACK_SLOT
    ) else $error("byte ended before the ninth clock");

    AST_STOP_CLOCK_HIGH: assert property (
        state == ST_STOP_C && $past(state) == ST_STOP_B
        |-> scl_oe_n && sda_oe_n && $past(scl_s)
    ) else $error("stop released data without clock high");

    AST_START_CLOCK_HIGH: assert property (
        state == ST_START_B && $past(state) == ST_START_A
        |-> !sda_oe_n && scl_oe_n
    ) else $error("start pulled data without clock high");

    COV_WRITE_BYTE: cover property (
        rsp_valid && !rsp.lost && !cur.rd
    );
    COV_READ_BYTE: cover property (
        rsp_valid && !rsp.lost && cur.rd
    );
    COV_LOST: cover property (
        rsp_valid && rsp.lost
    );
    COV_RESTART: cover property (
        state == ST_HOLD ##1 state == ST_RESTART
    );

endmodule : i2h_master

`default_nettype wire

// File: i2h_slave_model.sv
// behavioural addressed slave on the shared two-wire bus
`default_nettype none

module i2h_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a,
    parameter int STRETCH_NS = 30000
) (
    // bus lines and stretch enable
    input wire logic scl,
    input wire logic sda,
    input wire logic stretch_en,
    // open-drain pulls, high = line pulled low
    output logic scl_pull,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] rx_q[$];
    logic [7:0] tx_q[$];
    logic mack_q[$];
    int n_start = 0;
    int n_stop = 0;
    int bitc = 0;
    logic [7:0] sh = 8'h00;
    logic [7:0] tx = 8'h00;
    logic active = 1'b0, low_seen = 1'b0, sel = 1'b0, rd = 1'b0;
    logic addr_ph = 1'b0, xmit = 1'b0, mack = 1'b1;

    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    always @(negedge sda) begin
        if (scl === 1'b1) begin
            n_start++;
            active = 1'b1;
            low_seen = 1'b0;
            sel = 1'b0;
            xmit = 1'b0;
            addr_ph = 1'b1;
            bitc = 0;
        end
    end

    always @(posedge sda) begin
        if (scl === 1'b1 && active && low_seen) begin
            n_stop++;
            active = 1'b0;
        end
    end

    always @(posedge scl) begin
        if (active) begin
            if (bitc < 8) begin
                sh = {sh[6:0], sda};
                if (xmit && sda !== tx[7 - bitc]) xmit = 1'b0;
            end else begin
                mack = sda;
                if (sel && rd && !addr_ph) mack_q.push_back(sda);
            end
            bitc++;
        end
    end

    // every change of our data pull happens with the clock low
    always @(negedge scl) begin
        if (active) begin
            low_seen = 1'b1;
            sda_pull = 1'b0;
            if (bitc == 8) begin
                if (addr_ph) begin
                    sel = (sh[7:1] == ADDR);
                    rd = sh[0];
                    sda_pull = sel;
                end else if (sel && !rd) begin
                    rx_q.push_back(sh);
                    sda_pull = 1'b1;
                end
            end else if (bitc == 9) begin
                bitc = 0;
                xmit = sel && rd && (addr_ph || !mack);
                addr_ph = 1'b0;
                if (xmit) tx = (tx_q.size() > 0) ? tx_q.pop_front() : 8'hff;
            end
            if (xmit && bitc < 8) sda_pull = ~tx[7 - bitc];
            if (stretch_en && sel && bitc == 0 && !addr_ph) begin
                scl_pull = 1'b1;
                #(STRETCH_NS);
                scl_pull = 1'b0;
            end
        end
    end

endmodule : i2h_slave_model

`default_nettype wire

// File: tb.sv
// self-checking bench for the two-wire bus master
`default_nettype none

module tb
    import i2h_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic cmd_valid = 1'b0;
    i2h_cmd_t cmd = '0;
    logic cmd_ready, rsp_valid, bus_busy;
    i2h_rsp_t rsp;
    logic scl_o, sda_o, scl_oe_n, sda_oe_n, scl, sda, s_scl, s_sda;
    logic b_scl = 1'b0, b_sda = 1'b0, stretch = 1'b0;
    logic [31:0] seed = 32'h0000005a;
    logic [7:0] exp_rx[$];
    logic [7:0] exp_tx[$];
    logic exp_ack[$];
    logic [7:0] d;
    int fails = 0, total_checks = 0, exp_start = 0, exp_stop = 0, k, i;

    always #20 ref_clk = ~ref_clk;

    // wired-and with pull-ups on both lines
    assign scl = ~((~scl_oe_n & ~scl_o) | s_scl | b_scl);
    assign sda = ~((~sda_oe_n & ~sda_o) | s_sda | b_sda);

    i2h_master u_i2h_master (.ref_clk(ref_clk), .rstn(rstn),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp(rsp), .bus_busy(bus_busy),
        .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));

    i2h_slave_model u_i2h_slave_model (.scl(scl), .sda(sda),
        .stretch_en(stretch), .scl_pull(s_scl), .sda_pull(s_sda));

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic cycles(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cycles

    task automatic bounded(input int n);
        if (n <= 0) begin
            fails++;
            report_and_stop();
        end
    endtask : bounded

    task automatic send(input i2h_cmd_t c);
        int n;
        @(negedge ref_clk);
        cmd = c;
        cmd_valid = 1'b1;
        for (n = 20000; n > 0 && cmd_ready !== 1'b1; n--) @(negedge ref_clk);
        bounded(n);
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        if (c.start) exp_start++;
        if (c.stop) exp_stop++;
    endtask : send

    task automatic wait_rsp();
        int n;
        for (n = 40000; n > 0 && rsp_valid !== 1'b1; n--) @(negedge ref_clk);
        bounded(n);
    endtask : wait_rsp

    task automatic xfer(input logic st, input logic sp, input logic r,
                        input logic nk, input logic [7:0] dv,
                        input logic [7:0] ed, input logic en);
        send('{st, sp, r, nk, dv});
        wait_rsp();
        chk("rsp data", {24'h0, ed}, {24'h0, rsp.data});
        chk("rsp nack", {31'h0, en}, {31'h0, rsp.nack});
        chk("rsp lost", 32'h0, {31'h0, rsp.lost});
    endtask : xfer

    initial begin
        cycles(9);
        chk("scl oe in reset", 32'h1, {31'h0, scl_oe_n});
        chk("sda oe in reset", 32'h1, {31'h0, sda_oe_n});
        cycles(1);
        rstn = 1'b1;
        // single write of two random bytes
        xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h54, 8'h54, 1'b0);
        for (k = 0; k < 2; k++) begin
            d = rnd();
            exp_rx.push_back(d);
            xfer(1'b0, k == 1, 1'b0, 1'b0, d, d, 1'b0);
        end
        // address nobody answers
        xfer(1'b1, 1'b1, 1'b0, 1'b0, 8'h22, 8'h22, 1'b1);
        // single read of three bytes, last one not acknowledged
        // slave loads a byte at the falling edge ending the prior ack
        for (k = 0; k < 3; k++) begin
            d = rnd();
            exp_tx.push_back(d);
            u_i2h_slave_model.tx_q.push_back(d);
        end
        xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h55, 8'h55, 1'b0);
        for (k = 0; k < 3; k++) begin
            d = exp_tx.pop_front();
            exp_ack.push_back(k == 2);
            xfer(1'b0, k == 2, 1'b1, k == 2, 8'h00, d, k == 2);
        end
        // combined write then read with a stretching slave
        stretch = 1'b1;
        xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h54, 8'h54, 1'b0);
        d = rnd();
        exp_rx.push_back(d);
        xfer(1'b0, 1'b0, 1'b0, 1'b0, d, d, 1'b0);
        d = rnd();
        u_i2h_slave_model.tx_q.push_back(d);
        xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h55, 8'h55, 1'b0);
        exp_ack.push_back(1'b1);
        xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h00, d, 1'b1);
        stretch = 1'b0;
        // let our own stretched Stop finish before disturbing the bus
        for (i = 4000; i > 0 && cmd_ready !== 1'b1; i--) @(negedge ref_clk);
        bounded(i);
        // foreign start, bare data pulse, then a request while busy
        b_sda = 1'b1;
        exp_start++;
        cycles(10);
        chk("busy after start", 32'h1, {31'h0, bus_busy});
        b_sda = 1'b0;
        cycles(10);
        chk("busy after pulse", 32'h1, {31'h0, bus_busy});
        send('{1'b1, 1'b0, 1'b0, 1'b0, 8'h54});
        cycles(400);
        chk("scl held off", 32'h1, {31'h0, scl_oe_n});
        chk("sda held off", 32'h1, {31'h0, sda_oe_n});
        b_scl = 1'b1;
        cycles(100);
        b_sda = 1'b1;
        cycles(100);
        b_scl = 1'b0;
        cycles(100);
        b_sda = 1'b0;
        exp_stop++;
        wait_rsp();
        chk("nack after free", 32'h0, {31'h0, rsp.nack});
        d = rnd();
        exp_rx.push_back(d);
        xfer(1'b0, 1'b1, 1'b0, 1'b0, d, d, 1'b0);
        // competing master with a lower address holds data low
        send('{1'b1, 1'b0, 1'b0, 1'b0, 8'h54});
        for (i = 2000; i > 0 && scl_oe_n !== 1'b0; i--) @(negedge ref_clk);
        bounded(i);
        b_sda = 1'b1;
        wait_rsp();
        chk("lost flag", 32'h1, {31'h0, rsp.lost});
        cycles(2);
        chk("scl released", 32'h1, {31'h0, scl_oe_n});
        chk("sda released", 32'h1, {31'h0, sda_oe_n});
        b_sda = 1'b0;
        exp_stop++;
        cycles(10);
        chk("idle after stop", 32'h0, {31'h0, bus_busy});
        cycles(600);
        // bytes, acks and conditions as seen by the slave
        chk("rx count", exp_rx.size(),
            u_i2h_slave_model.rx_q.size());
        foreach (exp_rx[j])
            chk("rx byte", exp_rx[j], u_i2h_slave_model.rx_q[j]);
        chk("ack count", exp_ack.size(),
            u_i2h_slave_model.mack_q.size());
        foreach (exp_ack[j])
            chk("ack bit", exp_ack[j], u_i2h_slave_model.mack_q[j]);
        chk("starts", exp_start, u_i2h_slave_model.n_start);
        chk("stops", exp_stop, u_i2h_slave_model.n_stop);
        report_and_stop();
    end

endmodule : tb

`default_nettype wire
